/* File: design/txwp_map.vh */
/*
 * Register offsets, field positions and reset values of the 64-bit transmit
 * write port. Assumes inclusion by bare name from the design files.
 */
`ifndef TXWP_MAP_VH
`define TXWP_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TXWP_REG_CTRL       8'h00
`define TXWP_REG_STATUS     8'h04
`define TXWP_REG_MASK       8'h08
`define TXWP_REG_FILL       8'h0c
`define TXWP_REG_LINES      8'h10

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define TXWP_CTRL_THR_MSB   7
`define TXWP_CTRL_THR_LSB   0
`define TXWP_THR_RST        8'h06
`define TXWP_MASK_RST       4'h0
`define TXWP_EV_W           4
`define TXWP_EV_DROP        0
`define TXWP_EV_PATTERN     1
`define TXWP_EV_END         2
`define TXWP_EV_ERRED       3

`endif

/* File: design/txwp_sync.v */
/*
 * Two-flop synchroniser for a bundle of pin-level inputs.
 * Assumes every bit is a slow level relative to clk, sampled only by clk.
 */
module txwp_sync #(
   parameter W = 8
) (
   // System
   input  wire         clk,
   input  wire         rst_n,
   // Bundle
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);

   reg [W-1:0] meta;
   reg [W-1:0] stable;

   genvar g;
   generate
      for (g = 0; g < W; g = g + 1)
      begin : g_bit
         always @(posedge clk)
         begin
            if (!rst_n)
            begin
               meta[g]   <= 1'b0;
               stable[g] <= 1'b0;
            end
            else
            begin
               meta[g]   <= din[g];
               stable[g] <= meta[g];
            end
         end
      end
   endgenerate

   assign dout = stable;

endmodule // txwp_sync

/* File: design/txwp_write_port.v */
/*
 * 64-bit transmit write port of one buffer memory: pairs of 64-bit writes
 * build 128-bit lines inside eight partitions, which a round-robin service
 * drains onto the link side. Assumes all write pins, including the write
 * clock, are asynchronous to mclk and that the write clock is much slower
 * than mclk, so each pin level holds for several mclk cycles.
 */
`include "txwp_map.vh"

module txwp_write_port #(
   parameter DEPTH = 8,
   parameter PTR_W = 3
) (
   // System
   input  wire         mclk,
   input  wire         rst_n,
   // Write pins
   input  wire         tx_write_clock,
   input  wire [63:0]  tx_wide_write_data,
   input  wire [7:0]   tx_byte_lane_valid,
   input  wire         tx_packet_start_flag,
   input  wire         tx_packet_end_flag,
   input  wire         tx_packet_error_flag,
   input  wire         tx_write_strobe,
   input  wire [7:0]   tx_logical_port_number,
   input  wire [2:0]   tx_partition_select,
   input  wire         tx_line_terminate,
   input  wire         tx_buffer_service_disable,
   output reg          tx_partition_full,
   // Register port
   input  wire [7:0]   reg_addr,
   input  wire [31:0]  reg_wdata,
   input  wire         reg_wr,
   input  wire         reg_rd,
   output reg  [31:0]  reg_rdata,
   output reg          irq,
   // Link side
   output reg          link_valid,
   output reg  [127:0] link_data,
   output reg  [15:0]  link_lanes,
   output reg  [7:0]   link_port,
   output reg          link_sop,
   output reg          link_eop,
   output reg          link_err
);

   localparam NLINES = 8 * DEPTH;
   // Equals DEPTH, which is 2**PTR_W
   localparam [PTR_W:0] FULL_CNT = {1'b1, {PTR_W{1'b0}}};

   // -------------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------------
   function [PTR_W+2:0] line_idx;
      input [2:0]       part;
      input [PTR_W-1:0] ptr;
      begin
         line_idx = {part, ptr};
      end
   endfunction

   function lanes_ok;
      input [7:0] be;
      reg   [7:0] inv;
      begin
         inv      = ~be;
         lanes_ok = (be != 8'h00) && ((inv & (inv + 8'h01)) == 8'h00);
      end
   endfunction

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   wire [89:0] pin_raw;
   wire [89:0] pin_s;

   assign pin_raw = {tx_write_clock, tx_wide_write_data, tx_byte_lane_valid,
                     tx_packet_start_flag, tx_packet_end_flag,
                     tx_packet_error_flag, tx_write_strobe,
                     tx_logical_port_number, tx_partition_select,
                     tx_line_terminate, tx_buffer_service_disable};

   txwp_sync #(
      .W    (90)
   ) u_sync (
      .clk  (mclk),
      .rst_n(rst_n),
      .din  (pin_raw),
      .dout (pin_s)
   );

   wire        s_clk  = pin_s[89];
   wire [63:0] s_data = pin_s[88:25];
   wire [7:0]  s_be   = pin_s[24:17];
   wire        s_sop  = pin_s[16];
   wire        s_eop  = pin_s[15];
   wire        s_err  = pin_s[14];
   wire        s_we   = pin_s[13];
   wire [7:0]  s_port = pin_s[12:5];
   wire [2:0]  s_sel  = pin_s[4:2];
   wire        s_term = pin_s[1];
   wire        s_dis  = pin_s[0];

   // -------------------------------------------------------------------------
   // Write clock edge and lane masking
   // -------------------------------------------------------------------------
   reg clk_d;

   always @(posedge mclk)
   begin
      if (!rst_n)
         clk_d <= 1'b0;
      else
         clk_d <= s_clk;
   end

   wire wr_edge = s_clk & ~clk_d;

   wire [63:0] masked;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_lane
         assign masked[8*g+7:8*g] = s_be[g] ? s_data[8*g+7:8*g] : 8'h00;
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Partition state and storage
   // -------------------------------------------------------------------------
   reg [PTR_W-1:0] wptr [0:7];
   reg [PTR_W-1:0] rptr [0:7];
   reg [PTR_W:0]   cnt  [0:7];
   reg [7:0]       half;
   reg [127:0]     mem_data  [0:NLINES-1];
   reg [15:0]      mem_lanes [0:NLINES-1];
   reg [10:0]      mem_meta  [0:NLINES-1];
   reg [2:0]       rr;

   wire [2:0]       wp     = s_sel;
   wire             p_full = (cnt[wp] == FULL_CNT);
   wire [PTR_W+2:0] w_idx  = line_idx(wp, wptr[wp]);
   wire [PTR_W+2:0] r_idx  = line_idx(rr, rptr[rr]);

   wire wr_req   = wr_edge & s_we & (|s_be);
   wire do_store = wr_req & ~p_full;
   wire do_close = wr_edge & ~p_full &
                   ((do_store & (s_eop | half[wp])) | s_term);
   wire do_drop  = wr_edge & p_full & (wr_req | s_term);
   wire rd_go    = ~s_dis & (cnt[rr] != {(PTR_W+1){1'b0}});

   integer i;

   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         half <= 8'h00;
         rr   <= 3'h0;
         for (i = 0; i < 8; i = i + 1)
         begin
            wptr[i] <= {PTR_W{1'b0}};
            rptr[i] <= {PTR_W{1'b0}};
            cnt[i]  <= {(PTR_W+1){1'b0}};
         end
      end
      else
      begin
         rr <= rr + 3'h1;
         for (i = 0; i < 8; i = i + 1)
         begin
            if (do_close && (wp == i[2:0]) && !(rd_go && (rr == i[2:0])))
               cnt[i] <= cnt[i] + 1'b1;
            else if (!(do_close && (wp == i[2:0])) && rd_go && (rr == i[2:0]))
               cnt[i] <= cnt[i] - 1'b1;
         end
         if (do_close)
         begin
            wptr[wp] <= wptr[wp] + 1'b1;
            half[wp] <= 1'b0;
         end
         else if (do_store)
            half[wp] <= 1'b1;
         if (rd_go)
            rptr[rr] <= rptr[rr] + 1'b1;
      end
   end

   // Line contents carry no reset; the fill counts say which lines are live
   always @(posedge mclk)
   begin
      if (do_store && !half[wp])
      begin
         mem_data[w_idx]  <= {masked, 64'h0};
         mem_lanes[w_idx] <= {s_be, 8'h00};
         mem_meta[w_idx]  <= {s_sop, s_eop, s_err, s_port};
      end
      else if (do_store)
      begin
         mem_data[w_idx][63:0] <= masked;
         mem_lanes[w_idx][7:0] <= s_be;
         mem_meta[w_idx][9:8]  <= mem_meta[w_idx][9:8] | {s_eop, s_err};
      end
      else if (do_close && !half[wp])
      begin
         mem_lanes[w_idx] <= 16'h0000;
         mem_meta[w_idx]  <= {3'b000, s_port};
      end
   end

   // -------------------------------------------------------------------------
   // Link side service
   // -------------------------------------------------------------------------
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         link_valid <= 1'b0;
         link_data  <= 128'h0;
         link_lanes <= 16'h0000;
         link_port  <= 8'h00;
         link_sop   <= 1'b0;
         link_eop   <= 1'b0;
         link_err   <= 1'b0;
      end
      else if (rd_go)
      begin
         link_valid <= 1'b1;
         link_data  <= mem_data[r_idx];
         link_lanes <= mem_lanes[r_idx];
         link_port  <= mem_meta[r_idx][7:0];
         link_sop   <= mem_meta[r_idx][10];
         link_eop   <= mem_meta[r_idx][9];
         link_err   <= mem_meta[r_idx][8];
      end
      else
      begin
         link_valid <= 1'b0;
         link_data  <= 128'h0;
         link_lanes <= 16'h0000;
         link_port  <= 8'h00;
         link_sop   <= 1'b0;
         link_eop   <= 1'b0;
         link_err   <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Registers, events and interrupt
   // -------------------------------------------------------------------------
   reg [7:0]            thresh;
   reg [`TXWP_EV_W-1:0] status;
   reg [`TXWP_EV_W-1:0] mask;
   reg [31:0]           lines_sent;

   wire [7:0]  sel_cnt  = {{(7-PTR_W){1'b0}}, cnt[s_sel]};
   wire [7:0]  sel_wptr = {{(8-PTR_W){1'b0}}, wptr[s_sel]};
   wire [31:0] fill_word = {14'h0, s_dis, half[s_sel], sel_wptr, sel_cnt};

   wire [`TXWP_EV_W-1:0] ev;
   assign ev[`TXWP_EV_DROP]    = do_drop;
   assign ev[`TXWP_EV_PATTERN] = do_store & ~lanes_ok(s_be);
   assign ev[`TXWP_EV_END]     = do_store & s_eop;
   assign ev[`TXWP_EV_ERRED]   = do_store & s_eop & s_err;

   wire clr_status = reg_rd && (reg_addr == `TXWP_REG_STATUS);
   wire [`TXWP_EV_W-1:0] next_status = (clr_status ? {`TXWP_EV_W{1'b0}} : status) | ev;

   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         thresh            <= `TXWP_THR_RST;
         mask              <= `TXWP_MASK_RST;
         status            <= {`TXWP_EV_W{1'b0}};
         lines_sent        <= 32'h0;
         reg_rdata         <= 32'h0;
         irq               <= 1'b0;
         tx_partition_full <= 1'b0;
      end
      else
      begin
         status            <= next_status;
         irq               <= |(next_status & mask);
         tx_partition_full <= (sel_cnt >= thresh);
         if (rd_go)
            lines_sent <= lines_sent + 32'h1;
         if (reg_wr && (reg_addr == `TXWP_REG_CTRL))
            thresh <= reg_wdata[`TXWP_CTRL_THR_MSB:`TXWP_CTRL_THR_LSB];
         if (reg_wr && (reg_addr == `TXWP_REG_MASK))
            mask <= reg_wdata[`TXWP_EV_W-1:0];
         if (reg_rd)
         begin
            case (reg_addr)
               `TXWP_REG_CTRL:   reg_rdata <= {24'h0, thresh};
               `TXWP_REG_STATUS: reg_rdata <= {28'h0, status};
               `TXWP_REG_MASK:   reg_rdata <= {28'h0, mask};
               `TXWP_REG_FILL:   reg_rdata <= fill_word;
               `TXWP_REG_LINES:  reg_rdata <= lines_sent;
               default:          reg_rdata <= 32'h0;
            endcase
         end
         else
            reg_rdata <= 32'h0;
      end
   end

endmodule // txwp_write_port

/* File: testbench/txwp_chk.sv */
/* Port checker for txwp_write_port.
   Assumes binding to txwp_write_port; sees its ports only. */
module txwp_chk (
   // System
   input wire         mclk,
   input wire         rst_n,
   // Write pins
   input wire         tx_write_clock,
   input wire [2:0]   tx_partition_select,
   input wire         tx_buffer_service_disable,
   input wire         tx_partition_full,
   // Register port
   input wire [7:0]   reg_addr,
   input wire         reg_wr,
   input wire         reg_rd,
   input wire [31:0]  reg_rdata,
   // Link side
   input wire         link_valid,
   input wire [127:0] link_data,
   input wire [15:0]  link_lanes,
   input wire [7:0]   link_port,
   input wire         link_sop,
   input wire         link_eop,
   input wire         link_err
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [3:0] since;
   // Cycles since anything that may raise the full flag
   always @(posedge mclk)
   begin
      if (!rst_n || tx_write_clock || reg_wr || tx_partition_select != $past(tx_partition_select))
         since <= 4'h0;
      else if (since != 4'hf)
         since <= since + 4'h1;
   end
   sequence dis_held;
      tx_buffer_service_disable [*8];
   endsequence
   idle_words_a: assert property (!link_valid |-> link_data == 128'h0
      && link_lanes == 16'h0 && link_port == 8'h0 && !link_sop && !link_eop && !link_err)
      else $error("idle not zero");
   no_drain_a: assert property (dis_held |=> !link_valid) else $error("drain while off");
   lane_top_a: assert property (link_valid |-> link_lanes[15]) else $error("empty line");
   whole_half_a: assert property (link_valid && !link_eop |-> link_lanes[15:8] == 8'hff)
      else $error("partial half without end");
   err_end_a: assert property (link_valid && link_err |-> link_eop)
      else $error("err no end");
   full_cause_a: assert property ($rose(tx_partition_full) |-> since < 4'h8)
      else $error("full rose without cause");
   read_stand_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   unmapped_read_a: assert property (reg_rd && reg_addr == 8'hfc |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // txwp_chk

bind txwp_write_port txwp_chk u_chk (.mclk, .rst_n, .tx_write_clock, .tx_partition_select,
   .tx_buffer_service_disable, .tx_partition_full, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
   .link_valid, .link_data, .link_lanes, .link_port, .link_sop, .link_eop, .link_err);

/* File: testbench/txwp_writer.sv */
/* Writer logic on the far side of the write pins.
   Assumes mclk at 100 MHz; makes a 160 ns write clock only during a transfer. */
module txwp_writer (
   // Clock
   input  wire         mclk,
   // Write pins
   output logic        tx_write_clock,
   output logic [63:0] tx_wide_write_data,
   output logic [7:0]  tx_byte_lane_valid,
   output logic        tx_packet_start_flag,
   output logic        tx_packet_end_flag,
   output logic        tx_packet_error_flag,
   output logic        tx_write_strobe,
   output logic [7:0]  tx_logical_port_number,
   output logic [2:0]  tx_partition_select,
   output logic        tx_line_terminate,
   output logic        tx_buffer_service_disable
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {tx_write_clock, tx_write_strobe, tx_line_terminate, tx_buffer_service_disable} = 4'h0;
      {tx_packet_start_flag, tx_packet_end_flag, tx_packet_error_flag} = 3'h0;
      tx_wide_write_data = 64'h0;
      tx_byte_lane_valid = 8'h0;
      tx_logical_port_number = 8'h0;
      tx_partition_select = 3'h0;
   end
   // Pins held 70 ns before and 80 ns after the write clock rise
   task automatic xfer(input logic [63:0] d, input logic [7:0] be, input logic [2:0] fl,
      input logic we, input logic term, input logic [7:0] p, input logic [2:0] s);
      @(posedge mclk);
      tx_wide_write_data <= d;
      tx_byte_lane_valid <= be;
      {tx_packet_start_flag, tx_packet_end_flag, tx_packet_error_flag} <= fl;
      tx_write_strobe <= we;
      tx_line_terminate <= term;
      tx_logical_port_number <= p;
      tx_partition_select <= s;
      repeat (7) @(posedge mclk);
      tx_write_clock <= 1'b1;
      repeat (8) @(posedge mclk);
      tx_write_clock <= 1'b0;
      tx_wide_write_data <= ~d;
      tx_byte_lane_valid <= ~be;
      {tx_packet_start_flag, tx_packet_end_flag, tx_packet_error_flag} <= ~fl;
      tx_write_strobe <= 1'b0;
      tx_line_terminate <= 1'b0;
      tx_logical_port_number <= ~p;
   endtask
   task automatic hold_off(input logic v);
      @(posedge mclk);
      tx_buffer_service_disable <= v;
   endtask
endmodule // txwp_writer

/* File: testbench/test_txwp_write_port.sv */
/* Self-checking bench for txwp_write_port.
   Assumes txwp_writer on the pins and the checker bound to the port. */
module test_txwp_write_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, reg_wr, reg_rd;
   logic [7:0] reg_addr, l_port;
   logic [31:0] reg_wdata, rv;
   logic [127:0] l_data;
   logic [15:0] l_lanes;
   logic [2:0] l_fl, tx_partition_select;
   logic [63:0] tx_wide_write_data;
   logic [7:0] tx_byte_lane_valid, tx_logical_port_number;
   logic tx_write_clock, tx_packet_start_flag, tx_packet_end_flag, tx_packet_error_flag;
   logic tx_write_strobe, tx_line_terminate, tx_buffer_service_disable;
   wire [31:0] reg_rdata;
   wire [127:0] link_data;
   wire [15:0] link_lanes;
   wire [7:0] link_port;
   wire tx_partition_full, irq, link_valid, link_sop, link_eop, link_err;
   int err_count, checks, pulses;
   txwp_writer u_txwp_writer (.mclk, .tx_write_clock, .tx_wide_write_data, .tx_byte_lane_valid,
      .tx_packet_start_flag, .tx_packet_end_flag, .tx_packet_error_flag, .tx_write_strobe,
      .tx_logical_port_number, .tx_partition_select, .tx_line_terminate,
      .tx_buffer_service_disable);
   txwp_write_port u_txwp_write_port (.mclk, .rst_n, .tx_write_clock, .tx_wide_write_data,
      .tx_byte_lane_valid, .tx_packet_start_flag, .tx_packet_end_flag, .tx_packet_error_flag,
      .tx_write_strobe, .tx_logical_port_number, .tx_partition_select, .tx_line_terminate,
      .tx_buffer_service_disable, .tx_partition_full, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq, .link_valid, .link_data, .link_lanes, .link_port, .link_sop,
      .link_eop, .link_err);
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Last drained line
   always @(posedge mclk)
   begin
      if (link_valid === 1'b1)
      begin
         pulses <= pulses + 1;
         l_data <= link_data;
         l_lanes <= link_lanes;
         l_port <= link_port;
         l_fl <= {link_sop, link_eop, link_err};
      end
   end
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_r(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_link(input int n);
      for (int i = 0; i < 100 && pulses < n; i++) @(posedge mclk);
      #1;
   endtask
   task automatic t_reset;
      reg_r(8'h00, rv);
      chk(rv[7:0], 8'h06);
      reg_r(8'h08, rv);
      chk(rv[3:0], 4'h0);
      reg_r(8'hfc, rv);
      chk(rv, 32'h0);
   endtask
   task automatic t_pair;
      reg_w(8'h08, 32'h4);
      u_txwp_writer.xfer(64'h0123456789abcdef, 8'hff, 3'b100, 1, 0, 8'h5a, 3'h1);
      u_txwp_writer.xfer(64'hfedcba9876543210, 8'hf0, 3'b010, 1, 0, 8'h5a, 3'h1);
      wait_link(1);
      chk(l_data[127:32], {64'h0123456789abcdef, 32'hfedcba98});
      chk(l_lanes, 16'hfff0);
      chk({l_port, l_fl}, {8'h5a, 3'b110});
      chk(irq, 1'b1);
      reg_r(8'h04, rv);
      chk(rv[3:0], 4'h4);
      repeat (2) @(posedge mclk);
      #1 chk(irq, 1'b0);
   endtask
   task automatic t_first_end;
      u_txwp_writer.xfer(64'hc1c2000000000000, 8'hc0, 3'b111, 1, 0, 8'h21, 3'h4);
      wait_link(2);
      chk(l_data[127:112], 16'hc1c2);
      chk(l_lanes, 16'hc000);
      chk({l_port, l_fl}, {8'h21, 3'b111});
      reg_r(8'h04, rv);
      chk(rv[3:0], 4'hc);
   endtask
   task automatic t_drop;
      u_txwp_writer.xfer(64'h1, 8'h00, 3'b110, 1, 0, 8'h33, 3'h3);
      u_txwp_writer.xfer(64'h2, 8'hff, 3'b110, 0, 0, 8'h33, 3'h3);
      repeat (30) @(posedge mclk);
      chk(pulses, 2);
      reg_r(8'h0c, rv);
      chk(rv[16:0], 17'h0);
   endtask
   task automatic t_term;
      u_txwp_writer.xfer(64'h0bad0bad0bad0bad, 8'hff, 3'b100, 1, 0, 8'h44, 3'h5);
      reg_r(8'h0c, rv);
      chk(rv[16:0], 17'h10000);
      u_txwp_writer.xfer(64'h0, 8'h00, 3'b000, 0, 1, 8'h44, 3'h5);
      wait_link(3);
      chk({l_data[127:64], l_lanes, l_fl}, {64'h0bad0bad0bad0bad, 16'hff00, 3'b100});
      reg_r(8'h0c, rv);
      chk(rv[16:0], 17'h00100);
   endtask
   task automatic t_fill;
      reg_w(8'h08, 32'h0);
      reg_r(8'h04, rv);
      u_txwp_writer.hold_off(1'b1);
      for (int i = 0; i < 9; i++)
      begin
         u_txwp_writer.xfer(64'h80 << 56, 8'h80, 3'b110, 1, 0, 8'h60, 3'h2);
         #1;
         if (i == 4) chk(tx_partition_full, 1'b0);
         if (i == 5) chk(tx_partition_full, 1'b1);
      end
      chk(pulses, 3);
      chk(irq, 1'b0);
      reg_r(8'h0c, rv);
      chk(rv[17:0], 18'h20008);
      reg_r(8'h04, rv);
      chk(rv[3:0], 4'h5);
      u_txwp_writer.hold_off(1'b0);
      wait_link(11);
      chk({pulses[7:0], l_port}, {8'h0b, 8'h60});
      repeat (4) @(posedge mclk);
      #1 chk(tx_partition_full, 1'b0);
      reg_r(8'h10, rv);
      chk(rv, 32'h0000000b);
   endtask
   // Top-anchored but gapped lane pattern: stored byte by byte, flagged as bad
   task automatic t_pattern;
      reg_w(8'h08, 32'h2);
      u_txwp_writer.xfer(64'hb0b1b2b3b4b5b6b7, 8'hb0, 3'b110, 1, 0, 8'h62, 3'h2);
      wait_link(12);
      chk({l_data[127:64], l_lanes}, {64'hb000b2b300000000, 16'hb000});
      chk(irq, 1'b1);
      reg_r(8'h04, rv);
      chk(rv[3:0], 4'h6);
   endtask
   task automatic final_report;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 43'h0;
      {err_count, checks} = '0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_reset;
      t_pair;
      t_first_end;
      t_drop;
      t_term;
      t_fill;
      t_pattern;
      final_report;
   end
   initial
   begin
      #100000;
      err_count++;
      final_report;
   end
endmodule // test_txwp_write_port
